// ==== pcs_cfg_regs.sv ====
// Purpose: Status, class/revision and cache line size registers of one
//          configuration function, answering configuration cycles.
// Assumes: Bus engine delivers one-cycle event pulses synchronous to sys_clk.
// Notes:   Read data and acknowledge appear one cycle after the request.

`timescale 1ns/1ps
`default_nettype none

module pcs_cfg_regs
    import pcs_pkg::*;
#(
    parameter logic [2:0] FUNC_NUM = 3'h0,
    // Arbitrary neutral revision value
    parameter logic [7:0] REVISION = 8'h01
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic cfg_rd,
    input wire logic cfg_wr,
    input wire logic [2:0] cfg_func,
    input wire logic [7:0] cfg_addr,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    output logic cfg_ack,
    output logic [31:0] cfg_rdata,
    input wire logic addr_parity_err,
    input wire logic data_parity_err,
    input wire logic serr_request,
    input wire logic master_abort_rcvd,
    input wire logic target_abort_rcvd,
    input wire logic target_abort_sent,
    input wire logic perr_observed,
    input wire logic master_data_phase,
    input wire logic parity_response_enable,
    input wire logic system_error_enable,
    output logic perr_o_b,
    output logic perr_oe_b,
    output logic serr_o_b,
    output logic serr_oe_b,
    output logic [15:0] bus_error_status,
    output logic [7:0] cache_line_size
);

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    function automatic logic dword_hit(input logic [7:0] a,
                                       input logic [7:0] ofs);
        dword_hit = (a[7:2] == ofs[7:2]);
    endfunction

    // Only cycles for this function touch its registers
    wire logic func_sel = (cfg_func == FUNC_NUM); // RQ18
    wire logic wr_sel = cfg_wr && func_sel;
    wire logic rd_sel = cfg_rd && func_sel;
    wire logic hit_status = dword_hit(cfg_addr, PCS_OFS_STATUS);
    wire logic hit_class = dword_hit(cfg_addr, PCS_OFS_CLASS);
    wire logic hit_cls = dword_hit(cfg_addr, PCS_OFS_CLS);

    // ------------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------------
    logic [15:0] flags_q;
    logic [15:0] flags_d;
    logic [15:0] set_vec;
    logic [15:0] clr_vec;
    logic [15:0] status_val;
    logic perr_drive_d;
    logic serr_drive_d;

    // Offset 06h is the upper half of dword 04h: lanes 2 and 3
    wire logic status_wr = wr_sel && hit_status;
    wire logic [15:0] status_lane_mask = {{8{cfg_be[3]}}, {8{cfg_be[2]}}};
    assign clr_vec = status_wr ?
        (cfg_wdata[31:16] & status_lane_mask & PCS_STATUS_W1C_MASK) :
        16'h0000; // RQ1

    // Address parity is reported on the pin only with both enables
    assign serr_drive_d = system_error_enable &&
        ((addr_parity_err && parity_response_enable) || serr_request); // RQ20
    assign perr_drive_d = data_parity_err && parity_response_enable; // RQ19

    always_comb begin
        set_vec = 16'h0000;
        set_vec[PCS_BIT_DET_PAR] = addr_parity_err || data_parity_err; // RQ2
        set_vec[PCS_BIT_SIG_SERR] = serr_drive_d; // RQ3
        set_vec[PCS_BIT_RCV_MABT] = master_abort_rcvd; // RQ4
        set_vec[PCS_BIT_RCV_TABT] = target_abort_rcvd; // RQ5
        set_vec[PCS_BIT_SIG_TABT] = target_abort_sent; // RQ6
        set_vec[PCS_BIT_MST_DPAR] = perr_observed && master_data_phase &&
            parity_response_enable; // RQ8
    end

    // Hardwired fields reload every cycle, so a write can never move them
    wire logic [15:0] fixed_bits =
        PCS_STATUS_RESET & ~PCS_STATUS_W1C_MASK; // RQ7 RQ9 RQ10 RQ11
    assign status_val = flags_q; // RQ12 RQ13

    // Set beats clear so an error in the clearing cycle is kept
    assign flags_d = ((set_vec | (flags_q & ~clr_vec)) &
        PCS_STATUS_W1C_MASK) | fixed_bits; // RQ21

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            flags_q <= PCS_STATUS_RESET; // RQ14
        end else begin
            flags_q <= flags_d;
        end
    end

    // ------------------------------------------------------------------
    // Cache line size
    // ------------------------------------------------------------------
    logic [7:0] cls_q;
    logic [7:0] cls_d;
    wire logic cls_wr = wr_sel && hit_cls && cfg_be[0];
    assign cls_d = cls_wr ? cfg_wdata[7:0] : cls_q; // RQ17

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            cls_q <= PCS_CLS_RESET; // RQ17
        end else begin
            cls_q <= cls_d;
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    wire logic [31:0] class_val = {PCS_BASE_CLASS, PCS_SUB_CLASS,
                                   PCS_PROG_IF, REVISION}; // RQ15 RQ16
    // Lower half of dword 04h belongs to the command register kept
    // elsewhere; it reads zero here and the merge happens upstream.
    wire logic [31:0] rd_mux =
        hit_status ? {status_val, 16'h0000} :
        hit_class ? class_val :
        hit_cls ? {24'h00_0000, cls_q} :
        32'h0000_0000;

    logic ack_q;
    logic [31:0] rdata_q;
    logic perr_oe_b_q;
    logic serr_oe_b_q;
    logic pin_low_q;

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q <= rd_sel || wr_sel;
            rdata_q <= rd_sel ? rd_mux : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------
    // Open-drain error pins
    // ------------------------------------------------------------------
    // The pins only ever pull low, so the data flop stays at zero
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            perr_oe_b_q <= 1'b1;
            serr_oe_b_q <= 1'b1;
            pin_low_q <= 1'b0;
        end else begin
            perr_oe_b_q <= !perr_drive_d; // RQ19
            serr_oe_b_q <= !serr_drive_d; // RQ20
            pin_low_q <= 1'b0;
        end
    end

    assign cfg_ack = ack_q;
    assign cfg_rdata = rdata_q;
    assign perr_o_b = pin_low_q;
    assign perr_oe_b = perr_oe_b_q;
    assign serr_o_b = pin_low_q;
    assign serr_oe_b = serr_oe_b_q;
    assign bus_error_status = flags_q;
    assign cache_line_size = cls_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    sequence clear_req_s(int b);
        status_wr && cfg_wdata[16 + b] && cfg_be[2 + b / 8];
    endsequence

    sequence quiet_s(int b);
        !set_vec[b];
    endsequence

    sequence read_hit_s(h);
        rd_sel && h;
    endsequence

    w1c_clear_a: assert property ( // RQ1
        clear_req_s(PCS_BIT_RCV_MABT) and quiet_s(PCS_BIT_RCV_MABT)
        |=> !bus_error_status[PCS_BIT_RCV_MABT])
        else $error("write one did not clear master abort flag");

    zero_keeps_a: assert property ( // RQ1
        status_wr && !cfg_wdata[16 + PCS_BIT_SIG_TABT] &&
        bus_error_status[PCS_BIT_SIG_TABT]
        |=> bus_error_status[PCS_BIT_SIG_TABT])
        else $error("write zero disturbed target abort flag");

    parity_set_a: assert property ( // RQ2
        (addr_parity_err || data_parity_err)
        |=> bus_error_status[PCS_BIT_DET_PAR])
        else $error("detected parity flag not set");

    signaled_system_error_flag_a: assert property ( // RQ3
        $fell(serr_oe_b) |-> bus_error_status[PCS_BIT_SIG_SERR])
        else $error("system error driven without status flag");

    mabt_rec_a: assert property ( // RQ4
        master_abort_rcvd |=> bus_error_status[PCS_BIT_RCV_MABT])
        else $error("received master abort flag not set");

    received_target_abort_flag_a: assert property ( // RQ5
        target_abort_rcvd |=> bus_error_status[PCS_BIT_RCV_TABT])
        else $error("received target abort flag not set");

    signaled_target_abort_flag_a: assert property ( // RQ6
        target_abort_sent |=> bus_error_status[PCS_BIT_SIG_TABT])
        else $error("signaled target abort flag not set");

    fixed_bits_a: assert property ( // RQ7
        bus_error_status[10:9] == PCS_DEVSEL_MEDIUM)
        else $error("select timing bits wrong");

    dpar_cause_a: assert property ( // RQ8
        $rose(bus_error_status[PCS_BIT_MST_DPAR]) |->
        $past(perr_observed) && $past(master_data_phase) &&
        $past(parity_response_enable))
        else $error("data parity flag set without all conditions");

    status_reset_a: assert property ( // RQ14
        $rose(rst_b) |-> bus_error_status == 16'h0210)
        else $error("status reset value wrong");

    class_read_a: assert property ( // RQ15
        rd_sel && hit_class |=> cfg_ack &&
        cfg_rdata == {16'h0607, 8'h00, REVISION})
        else $error("class register read wrong");

    cls_hold_a: assert property ( // RQ17
        cls_wr ##1 (!cls_wr) [*3] |-> cache_line_size == $past(cls_d, 3))
        else $error("cache line size did not hold written value");

    set_wins_a: assert property ( // RQ21
        clear_req_s(PCS_BIT_DET_PAR) and addr_parity_err
        |=> bus_error_status[PCS_BIT_DET_PAR])
        else $error("clear beat a same cycle parity event");

    perr_gate_a: assert property ( // RQ19
        !perr_oe_b |-> $past(parity_response_enable) &&
        $past(data_parity_err))
        else $error("parity pin driven without enable");

    serr_gate_a: assert property ( // RQ20
        $past(addr_parity_err) && !$past(parity_response_enable) &&
        !$past(serr_request) |-> serr_oe_b)
        else $error("system error pin driven without parity enable");

    w1c_par_a: assert property ( // RQ1
        clear_req_s(PCS_BIT_DET_PAR) and quiet_s(PCS_BIT_DET_PAR)
        |=> !bus_error_status[PCS_BIT_DET_PAR])
        else $error("write one did not clear parity flag");

    w1c_serr_a: assert property ( // RQ1
        clear_req_s(PCS_BIT_SIG_SERR) and quiet_s(PCS_BIT_SIG_SERR)
        |=> !bus_error_status[PCS_BIT_SIG_SERR])
        else $error("write one did not clear system error flag");

    w1c_rtabt_a: assert property ( // RQ1
        clear_req_s(PCS_BIT_RCV_TABT) and quiet_s(PCS_BIT_RCV_TABT)
        |=> !bus_error_status[PCS_BIT_RCV_TABT])
        else $error("write one did not clear received abort flag");

    w1c_stabt_a: assert property ( // RQ1
        clear_req_s(PCS_BIT_SIG_TABT) and quiet_s(PCS_BIT_SIG_TABT)
        |=> !bus_error_status[PCS_BIT_SIG_TABT])
        else $error("write one did not clear signaled abort flag");

    w1c_dpar_a: assert property ( // RQ1
        clear_req_s(PCS_BIT_MST_DPAR) and quiet_s(PCS_BIT_MST_DPAR)
        |=> !bus_error_status[PCS_BIT_MST_DPAR])
        else $error("write one did not clear data parity flag");

    flags_hold_a: assert property ( // RQ1
        !status_wr |=> (bus_error_status & $past(bus_error_status)) ==
            $past(bus_error_status))
        else $error("status flag lost without a write");

    serr_flag_gate_a: assert property ( // RQ3
        $rose(bus_error_status[PCS_BIT_SIG_SERR]) |->
        $past(system_error_enable))
        else $error("system error flag set while disabled");

    dpar_set_a: assert property ( // RQ8
        perr_observed && master_data_phase && parity_response_enable
        |=> bus_error_status[PCS_BIT_MST_DPAR])
        else $error("data parity flag not set");

    perr_drive_a: assert property ( // RQ19
        data_parity_err && parity_response_enable |=> !perr_oe_b)
        else $error("parity pin not driven");

    serr_drive_a: assert property ( // RQ20
        system_error_enable &&
        (serr_request || (addr_parity_err && parity_response_enable))
        |=> !serr_oe_b)
        else $error("system error pin not driven");

    pins_low_a: assert property ( // RQ19 RQ20
        !perr_o_b && !serr_o_b)
        else $error("error pin data not low");

    other_func_a: assert property ( // RQ18
        (cfg_rd || cfg_wr) && (cfg_func != FUNC_NUM) |=> !cfg_ack)
        else $error("access to another function answered");

    other_keep_a: assert property ( // RQ18
        cfg_wr && (cfg_func != FUNC_NUM) &&
        bus_error_status[PCS_BIT_RCV_MABT]
        |=> bus_error_status[PCS_BIT_RCV_MABT])
        else $error("write to another function cleared a flag");

    ack_taken_a: assert property ( // RQ18
        rd_sel || wr_sel |=> cfg_ack)
        else $error("taken access not acknowledged");

    status_read_a: assert property ( // RQ14
        read_hit_s(hit_status) |=>
        cfg_rdata == {$past(bus_error_status), 16'h0000})
        else $error("status register read wrong");

    cls_read_a: assert property ( // RQ17
        read_hit_s(hit_cls) |=>
        cfg_rdata == {24'h00_0000, $past(cache_line_size)})
        else $error("cache line size read wrong");

    cls_write_a: assert property ( // RQ17
        cls_wr |=> cache_line_size == $past(cfg_wdata[7:0]))
        else $error("cache line size write lost");

    cls_keep_a: assert property ( // RQ17
        !cls_wr |=> $stable(cache_line_size))
        else $error("cache line size changed without a write");

    abort_wins_a: assert property ( // RQ21
        clear_req_s(PCS_BIT_RCV_MABT) and master_abort_rcvd
        |=> bus_error_status[PCS_BIT_RCV_MABT])
        else $error("clear beat a same cycle abort event");

    cap_bits_a: assert property ( // RQ9 RQ10 RQ11 RQ12
        bus_error_status[7:4] == 4'h1)
        else $error("capability bits wrong");

    rsvd_zero_a: assert property ( // RQ13
        bus_error_status[3:0] == 4'h0)
        else $error("reserved status bits not zero");

endmodule

`default_nettype wire

// ==== pcs_host_model.sv ====
// Purpose: Host that issues configuration reads and writes.
// Assumes: One-cycle request pulse, answer one edge later.
// Notes:   Released lines flip so a stale value never passes.
`timescale 1ns/1ps
`default_nettype none
module pcs_host_model (
    input wire logic sys_clk,
    output logic cfg_rd,
    output logic cfg_wr,
    output logic [2:0] cfg_func,
    output logic [7:0] cfg_addr,
    output logic [3:0] cfg_be,
    output logic [31:0] cfg_wdata
);
    initial begin
        cfg_rd = 1'b0;
        cfg_wr = 1'b0;
        cfg_func = 3'h0;
        cfg_addr = 8'h00;
        cfg_be = 4'h0;
        cfg_wdata = 32'h0000_0000;
    end
    task automatic acc(input logic w, input logic [2:0] f,
        input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        @(posedge sys_clk);
        cfg_rd <= !w;
        cfg_wr <= w;
        cfg_func <= f;
        cfg_addr <= a;
        cfg_be <= be;
        cfg_wdata <= d;
        @(posedge sys_clk);
        cfg_rd <= 1'b0;
        cfg_wr <= 1'b0;
        cfg_addr <= ~a;
        cfg_be <= ~be;
        cfg_wdata <= ~d;
        @(posedge sys_clk);
    endtask
endmodule
`default_nettype wire

// ==== pcs_pkg.sv ====
// Purpose: Constants for the configuration status, class and cache line
//          size registers of one bridge function.
// Assumes: Byte addresses within the function's configuration header.
// Notes:   Reserved and hardwired bits are built from these constants.
//
// What this block does
// RQ1: Writing one to a status flag clears it; writing zero leaves it.
// RQ2: Status bit 15 sets on any detected address or data parity error.
// RQ3: Status bit 14 sets when enabled system error is signalled.
// RQ4: Status bit 13 sets when our master cycle ends in master abort.
// RQ5: Status bit 12 sets when our master cycle receives a target abort.
// RQ6: Status bit 11 sets when we, as target, signal a target abort.
// RQ7: Status bits 10..9 read only, hardwired to medium select timing 01b.
// RQ8: Status bit 8 sets on parity error seen while master, response enabled.
// RQ9: Status bit 7, fast back-to-back capable, always reads zero.
// RQ10: Status bit 6, user definable features, always reads zero.
// RQ11: Status bit 5, high speed capable, always reads zero.
// RQ12: Status bit 4, capability list present, always reads one.
// RQ13: Status bits 3..0 are reserved and read zero.
// RQ14: Status sits at offset 06h and resets to 0210h.
// RQ15: Class register reads bridge, card bus bridge, interface zero.
// RQ16: Lowest class register byte returns the silicon revision, read only.
// RQ17: Cache line size is an 8-bit read/write register resetting to zero.
// RQ18: Each configuration function presents its own bus status register.
// RQ19: Parity response enable gates driving of the parity error pin.
// RQ20: System error pin drives only with both enables for address parity.
// RQ21: A set event wins over a same-cycle write-one clear.

`default_nettype none

package pcs_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] PCS_OFS_STATUS = 8'h06;
    localparam logic [7:0] PCS_OFS_CLASS = 8'h08;
    localparam logic [7:0] PCS_OFS_CLS = 8'h0c;

    // ------------------------------------------------------------------
    // Status field positions
    // ------------------------------------------------------------------
    localparam int PCS_BIT_DET_PAR = 15;
    localparam int PCS_BIT_SIG_SERR = 14;
    localparam int PCS_BIT_RCV_MABT = 13;
    localparam int PCS_BIT_RCV_TABT = 12;
    localparam int PCS_BIT_SIG_TABT = 11;
    localparam int PCS_BIT_MST_DPAR = 8;

    // ------------------------------------------------------------------
    // Hardwired and reset values
    // ------------------------------------------------------------------
    localparam logic [1:0] PCS_DEVSEL_MEDIUM = 2'h1;
    localparam logic [15:0] PCS_STATUS_RESET = 16'h0210;
    localparam logic [15:0] PCS_STATUS_W1C_MASK = 16'hf900;
    localparam logic [7:0] PCS_BASE_CLASS = 8'h06;
    localparam logic [7:0] PCS_SUB_CLASS = 8'h07;
    localparam logic [7:0] PCS_PROG_IF = 8'h00;
    localparam logic [7:0] PCS_CLS_RESET = 8'h00;

endpackage

`default_nettype wire

// ==== test_pci_cfg_status_class_cls.sv ====
// Purpose: Self-checking bench for the status, class and line size regs.
// Assumes: Answers come one edge after the request is taken.
// Notes:   Expected read data is queued by the driver.
`timescale 1ns/1ps
`default_nettype none
module test_pci_cfg_status_class_cls import pcs_pkg::*; ;
    // Arbitrary revision value
    localparam logic [7:0] REV = 8'h5a;
    localparam logic [15:0] SM [7] = '{16'hc000, 16'h8000, 16'h4000,
        16'h2000, 16'h1000, 16'h0800, 16'h0000};
    logic sys_clk, rst_b, cfg_rd, cfg_wr, cfg_ack, pre, sys, mdp;
    logic perr_o_b, perr_oe_b, serr_o_b, serr_oe_b;
    logic [2:0] cfg_func;
    logic [7:0] cfg_addr, cache_line_size;
    logic [3:0] cfg_be;
    logic [31:0] cfg_wdata, cfg_rdata, v;
    logic [15:0] bus_error_status;
    logic [6:0] ev;
    logic [31:0] q [$];
    integer seed = 32'h46d2;
    int fail_count = 0;
    int n_checks = 0;

    pcs_host_model host (.sys_clk(sys_clk), .cfg_rd(cfg_rd),
        .cfg_wr(cfg_wr), .cfg_func(cfg_func), .cfg_addr(cfg_addr),
        .cfg_be(cfg_be), .cfg_wdata(cfg_wdata));
    pcs_cfg_regs #(.REVISION(REV)) dut (.sys_clk(sys_clk), .rst_b(rst_b),
        .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_func(cfg_func),
        .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
        .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
        .addr_parity_err(ev[0]), .data_parity_err(ev[1]),
        .serr_request(ev[2]), .master_abort_rcvd(ev[3]),
        .target_abort_rcvd(ev[4]), .target_abort_sent(ev[5]),
        .perr_observed(ev[6]), .master_data_phase(mdp),
        .parity_response_enable(pre), .system_error_enable(sys),
        .perr_o_b(perr_o_b), .perr_oe_b(perr_oe_b), .serr_o_b(serr_o_b),
        .serr_oe_b(serr_oe_b), .bus_error_status(bus_error_status),
        .cache_line_size(cache_line_size));

    // ------------------------------------------------------------
    // Checking
    // ------------------------------------------------------------
    task automatic cmp_rd(input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %0t read exp %h got %h", $time, e, g);
        end
    endtask
    task automatic cmp_out(input logic [31:0] e, input logic [31:0] g,
        input string m);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %0t %s exp %h got %h", $time, m, e, g);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        if (cfg_ack === 1'b1) begin
            if (q.size() == 0) begin
                fail_count++;
                $display("mismatch %0t unexpected answer", $time);
            end else begin
                cmp_rd(q.pop_front(), cfg_rdata);
            end
        end
    end

    // ------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------
    task automatic rd(input logic [2:0] f, input logic [7:0] a,
        input logic [31:0] e);
        q.push_back(e);
        host.acc(1'b0, f, a, 4'hf, $random(seed));
    endtask
    task automatic wr(input logic [7:0] a, input logic [3:0] be,
        input logic [31:0] d);
        q.push_back(32'h0000_0000);
        host.acc(1'b1, 3'h0, a, be, d);
    endtask
    task automatic pulse(input int i);
        @(posedge sys_clk);
        ev[i] <= 1'b1;
        @(posedge sys_clk);
        ev[i] <= 1'b0;
        @(posedge sys_clk);
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    initial begin
        #(40 * 5000);
        fail_count++;
        report_and_stop();
    end
    initial begin
        rst_b = 1'b0;
        ev = 7'h00;
        pre = 1'b1;
        sys = 1'b1;
        mdp = 1'b0;
        repeat (10) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        cmp_out(16'h0210, bus_error_status, "status");
        cmp_out(2'h0, {perr_o_b, serr_o_b}, "pins");
        rd(3'h0, 8'h06, 32'h0210_0000);
        rd(3'h0, 8'h08, {24'h06_0700, REV});
        rd(3'h0, 8'h0c, 32'h0000_0000);
        $display("test reset done");
        for (int i = 0; i < 7; i++) begin
            pulse(i);
            cmp_out(!(i == 0 || i == 2), serr_oe_b, "serr");
            cmp_out(i != 1, perr_oe_b, "perr");
            rd(3'h0, 8'h04, {16'h0210 | SM[i], 16'h0});
            wr(8'h04, 4'hc, 32'h0000_0000);
            rd(3'h0, 8'h04, {16'h0210 | SM[i], 16'h0});
            wr(8'h04, 4'hc, 32'hffff_ffff);
            cmp_out(16'h0210, bus_error_status, "w1c");
        end
        $display("test events done");
        mdp <= 1'b1;
        pulse(6);
        cmp_out(16'h0310, bus_error_status, "dpar");
        wr(8'h04, 4'hc, 32'h0100_0000);
        pre <= 1'b0;
        pulse(6);
        pulse(0);
        cmp_out(1'b1, serr_oe_b, "serr gate");
        pre <= 1'b1;
        sys <= 1'b0;
        pulse(2);
        cmp_out(16'h8210, bus_error_status, "gates");
        fork
            wr(8'h04, 4'hc, 32'hffff_0000);
            pulse(0);
        join
        cmp_out(16'h8210, bus_error_status, "race par");
        fork
            wr(8'h04, 4'hc, 32'hffff_0000);
            pulse(3);
        join
        cmp_out(16'h2210, bus_error_status, "race");
        $display("test gating done");
        v = $random(seed);
        wr(8'h0c, 4'h1, v);
        rd(3'h0, 8'h0c, {24'h0, v[7:0]});
        wr(8'h0c, 4'he, ~v);
        cmp_out(v[7:0], cache_line_size, "cls");
        wr(8'h08, 4'hf, v);
        rd(3'h0, 8'h08, {24'h06_0700, REV});
        rd(3'h0, 8'h40, 32'h0000_0000);
        host.acc(1'b1, 3'h1, 8'h04, 4'hc, 32'hffff_0000);
        host.acc(1'b0, 3'h1, 8'h08, 4'hf, v);
        cmp_out(16'h2210, bus_error_status, "func");
        repeat (3) @(posedge sys_clk);
        cmp_out(32'h0, q.size(), "queue");
        $display("test access done");
        report_and_stop();
    end
endmodule
`default_nettype wire
